// *** bench/bbnio_host_model.sv ***
// Upstream host issuing configuration accesses
`timescale 1ns/10ps
`default_nettype none
module bbnio_host_model (
    // Clock
    input  wire logic        i_clk,
    // Request
    output logic             o_wr,
    output logic             o_rd,
    output logic      [7:0]  o_addr,
    output logic      [3:0]  o_be,
    output logic      [31:0] o_wdata,
    // Answer
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_hit
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'hFF;
        o_be = 4'h0;
        o_wdata = 32'h0;
    end
    // One access: held over the taking edge, answer picked up next
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                          output logic [31:0] q, output logic h);
        @(negedge i_clk);
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_be = be;
        o_wdata = d;
        @(negedge i_clk);
        q = i_rdata;
        h = i_hit;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = ~a;
        o_be = 4'h0;
        o_wdata = ~d;
    endtask
endmodule // bbnio_host_model
`default_nettype wire

// *** bench/bbnio_regs_assertions.sv ***
// Concurrent checks on the bus-number and I/O window register ports
`timescale 1ns/10ps
`default_nettype none
module bbnio_regs_assertions (
    // Clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    // Configuration access
    input wire logic        i_cfg_wr,
    input wire logic        i_cfg_rd,
    input wire logic [7:0]  i_cfg_addr,
    input wire logic [3:0]  i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [31:0] o_cfg_rdata,
    input wire logic        o_cfg_rvalid,
    // Steering
    input wire logic        i_t1_valid,
    input wire logic [7:0]  i_t1_bus,
    input wire logic        o_t1_to_type0,
    input wire logic        o_t1_pass_type1,
    input wire logic        i_io_valid,
    input wire logic [31:0] i_io_addr,
    input wire logic        o_io_forward,
    // Register values
    input wire logic [7:0]  o_downstream_bus_num,
    input wire logic [7:0]  o_highest_downstream_bus_num,
    input wire logic [7:0]  o_downstream_latency_timer,
    input wire logic [31:0] o_io_bottom,
    input wire logic [31:0] o_io_top
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence wr_bot_s;
        i_cfg_wr && i_cfg_addr[7:2] == 6'h07 && i_cfg_be[0];
    endsequence
    sequence wr_top_s;
        i_cfg_wr && i_cfg_addr[7:2] == 6'h07 && i_cfg_be[1];
    endsequence
    // Window outputs settle two edges after a write
    sequence quiet_s;
        !i_cfg_wr ##1 !i_cfg_wr ##1 !i_cfg_wr;
    endsequence
    rd_answer_a: assert property (i_cfg_rd |=> o_cfg_rvalid)
        else $error("read answer missing");
    bot_assemble_a: assert property (wr_bot_s |-> ##2 o_io_bottom[15:0] == {$past(i_cfg_wdata[7:4], 2), 12'h000})
        else $error("window bottom wrong");
    top_assemble_a: assert property (wr_top_s |-> ##2 o_io_top[15:0] == {$past(i_cfg_wdata[15:12], 2), 12'hFFF})
        else $error("window top wrong");
    lat_write_a: assert property (i_cfg_wr && i_cfg_addr[7:2] == 6'h06 && i_cfg_be[3] |=>
        o_downstream_latency_timer == $past(i_cfg_wdata[31:24])) else $error("latency byte not written");
    width_code_a: assert property (i_cfg_rd && i_cfg_addr[7:2] == 6'h07 |=>
        o_cfg_rdata[3:0] == 4'h1 && o_cfg_rdata[11:8] == 4'h1) else $error("width code wrong");
    to_type0_a: assert property (i_t1_valid && i_t1_bus == o_downstream_bus_num |=>
        o_t1_to_type0 && !o_t1_pass_type1) else $error("type 0 conversion missing");
    pass_type1_a: assert property (i_t1_valid && i_t1_bus > o_downstream_bus_num &&
        i_t1_bus <= o_highest_downstream_bus_num |=> o_t1_pass_type1) else $error("type 1 pass missing");
    io_forward_a: assert property (quiet_s ##0 i_io_valid |=>
        o_io_forward == $past(i_io_addr >= o_io_bottom && i_io_addr <= o_io_top)) else $error("forward wrong");
endmodule // bbnio_regs_assertions
bind bbnio_regs bbnio_regs_assertions i_chk (.*);
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the bus-number and I/O window registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    logic        i_ref_clk;
    logic        i_rst_n;
    logic        i_cfg_wr;
    logic        i_cfg_rd;
    logic [7:0]  i_cfg_addr;
    logic [3:0]  i_cfg_be;
    logic [31:0] i_cfg_wdata;
    logic [31:0] o_cfg_rdata;
    logic        o_cfg_rvalid;
    logic        o_cfg_hit;
    logic        i_t1_valid;
    logic [7:0]  i_t1_bus;
    logic        o_t1_to_type0;
    logic        o_t1_pass_type1;
    logic        o_t1_reject;
    logic        i_io_valid;
    logic [31:0] i_io_addr;
    logic        o_io_forward;
    logic [7:0]  o_upstream_bus_num;
    logic [7:0]  o_downstream_bus_num;
    logic [7:0]  o_highest_downstream_bus_num;
    logic [7:0]  o_downstream_latency_timer;
    logic [31:0] o_io_bottom;
    logic [31:0] o_io_top;
    logic [31:0] q;
    logic        h;
    int          errors;
    int          comparisons;
    logic [31:0] io_tab [4] = '{32'h0004_1FFF, 32'h0004_2000, 32'h0005_3FFF, 32'h0005_4000};
    logic        io_exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic [2:0]  t1_exp [4] = '{3'b001, 3'b100, 3'b010, 3'b001};

    bbnio_regs i_dut (.*);
    bbnio_host_model i_host (.i_clk(i_ref_clk), .o_wr(i_cfg_wr), .o_rd(i_cfg_rd), .o_addr(i_cfg_addr),
                             .o_be(i_cfg_be), .o_wdata(i_cfg_wdata), .i_rdata(o_cfg_rdata), .i_hit(o_cfg_hit));

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        i_host.access(1'b1, a, be, d, q, h);
        `CHK("wr hit", 1'b1, h)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic eh);
        i_host.access(1'b0, a, 4'hF, 32'h0, q, h);
        `CHK("rdata", e, q)
        `CHK("hit", eh, h)
        `CHK("rvalid", 1'b1, o_cfg_rvalid)
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #4000;
        errors++;
        wrap_up();
    end
    initial begin
        errors = 0;
        comparisons = 0;
        i_rst_n = 1'b0;
        i_t1_valid = 1'b0;
        i_t1_bus = 8'h00;
        i_io_valid = 1'b0;
        i_io_addr = 32'h0;
        repeat (20) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        repeat (3) @(posedge i_ref_clk);
        rd(8'h18, 32'h0000_0000, 1'b1);
        rd(8'h1C, 32'h0000_0101, 1'b1);
        rd(8'h30, 32'h0000_0000, 1'b1);
        `CHK("rst bottom", 32'h0000_0000, o_io_bottom)
        `CHK("rst top", 32'h0000_0FFF, o_io_top)
        $display("test reset_values done");
        wr(8'h18, 4'hF, 32'h0403_0201);
        rd(8'h18, 32'h0403_0201, 1'b1);
        wr(8'h18, 4'h1, 32'hFFFF_FF09);
        rd(8'h18, 32'h0403_0209, 1'b1);
        `CHK("upstream", 8'h09, o_upstream_bus_num)
        `CHK("downstream", 8'h02, o_downstream_bus_num)
        `CHK("highest", 8'h03, o_highest_downstream_bus_num)
        `CHK("latency", 8'h04, o_downstream_latency_timer)
        rd(8'h20, 32'h0000_0000, 1'b0);
        $display("test bus_numbers done");
        wr(8'h1C, 4'hF, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0000_F1F1, 1'b1);
        wr(8'h1C, 4'h3, 32'h0000_3020);
        wr(8'h30, 4'hF, 32'h0005_0004);
        rd(8'h30, 32'h0005_0004, 1'b1);
        `CHK("bottom", 32'h0004_2000, o_io_bottom)
        `CHK("top", 32'h0005_3FFF, o_io_top)
        for (int i = 0; i < 4; i++) begin
            @(negedge i_ref_clk);
            i_io_valid = 1'b1;
            i_io_addr = io_tab[i];
            i_t1_valid = 1'b1;
            i_t1_bus = 8'(i + 1);
            @(negedge i_ref_clk);
            i_io_valid = 1'b0;
            i_t1_valid = 1'b0;
            `CHK("forward", io_exp[i], o_io_forward)
            `CHK("route", t1_exp[i], {o_t1_to_type0, o_t1_pass_type1, o_t1_reject})
        end
        $display("test window_and_steering done");
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

// *** verilog/bbnio_cfg_route.sv ***
// Type 1 configuration bus-number steering
`timescale 1ns/10ps
`default_nettype none

module bbnio_cfg_route (
    // Bus numbers
    input  wire logic [7:0]  i_dn_bus,
    input  wire logic [7:0]  i_hi_bus,
    // Request
    input  wire logic [7:0]  i_target_bus,
    // Decision
    output bbnio_pkg::bbnio_route_e o_route
);

    always_comb begin
        if (i_target_bus == i_dn_bus) begin
            o_route = bbnio_pkg::BBNIO_CFG_TO_TYPE0;           // [RQ4] [RQ14]
        end else if (i_target_bus > i_dn_bus && i_target_bus <= i_hi_bus) begin
            o_route = bbnio_pkg::BBNIO_CFG_PASS_TYPE1;         // [RQ4] [RQ14]
        end else begin
            o_route = bbnio_pkg::BBNIO_CFG_NONE;
        end
    end

endmodule // bbnio_cfg_route
`default_nettype wire

// *** verilog/bbnio_io_window.sv ***
// I/O window assembly and inclusive address compare
`timescale 1ns/10ps
`default_nettype none
`include "bbnio_params.svh"

module bbnio_io_window (
    // Programmed window fields
    input  wire logic [3:0]  i_bot_nibble,
    input  wire logic [3:0]  i_top_nibble,
    input  wire logic [15:0] i_bot_upper,
    input  wire logic [15:0] i_top_upper,
    // Address to test
    input  wire logic [31:0] i_addr,
    // Result
    output logic      [31:0] o_bottom,
    output logic      [31:0] o_top,
    output logic             o_hit
);

    always_comb begin
        o_bottom = {i_bot_upper, i_bot_nibble, `BBNIO_IO_BOT_LOW}; // [RQ6] [RQ8] [RQ11]
        o_top    = {i_top_upper, i_top_nibble, `BBNIO_IO_TOP_LOW}; // [RQ7] [RQ9] [RQ12]
        o_hit    = (i_addr >= o_bottom) && (i_addr <= o_top);       // [RQ13]
    end

endmodule // bbnio_io_window
`default_nettype wire

// *** verilog/bbnio_params.svh ***
// Offsets, field positions, reset values of the bus-number and I/O window registers
`ifndef BBNIO_PARAMS_SVH
`define BBNIO_PARAMS_SVH

`define BBNIO_OFF_UP_BUS      8'h18
`define BBNIO_OFF_DN_BUS      8'h19
`define BBNIO_OFF_HI_BUS      8'h1A
`define BBNIO_OFF_LAT_TMR     8'h1B
`define BBNIO_OFF_IO_BOT      8'h1C
`define BBNIO_OFF_IO_TOP      8'h1D
`define BBNIO_OFF_IO_BOT_UP   8'h30
`define BBNIO_OFF_IO_TOP_UP   8'h32

`define BBNIO_RST_BYTE        8'h00
`define BBNIO_RST_UPPER       16'h0000
`define BBNIO_RST_NIBBLE      4'h0
`define BBNIO_IO_WIDTH_CODE   4'h1
`define BBNIO_IO_BOT_LOW      12'h000
`define BBNIO_IO_TOP_LOW      12'hFFF

`endif

// *** verilog/bbnio_pkg.sv ***
// Types shared by the bus-number and I/O window register bank
package bbnio_pkg;

    typedef enum logic [1:0] {
        BBNIO_CFG_NONE,
        BBNIO_CFG_TO_TYPE0,
        BBNIO_CFG_PASS_TYPE1
    } bbnio_route_e;

endpackage

// *** verilog/bbnio_regs.sv ***
// Bus-number, latency timer and I/O window configuration registers of the bridge
// Notes on behaviour
// [RQ1] Upstream bus number byte, read/write, resets zero
// [RQ2] Downstream bus number byte, read/write, resets zero
// [RQ3] Highest downstream bus byte, read/write, resets zero
// [RQ4] Type 1 requests steered by bus-number compare
// [RQ5] Latency timer byte in PCI clocks, resets zero
// [RQ6] Window bottom comes from bottom register
// [RQ7] Window top comes from top register
// [RQ8] Bottom nibble is address 15:12, low zeros
// [RQ9] Top nibble is address 15:12, low ones
// [RQ10] Low nibbles read 1h, writes ignored
// [RQ11] Bottom bits 31:16 from register at 30h
// [RQ12] Top bits 31:16 from register at 32h
// [RQ13] Window hit is inclusive at both ends
// [RQ14] Equal secondary to type 0, range passes type 1
`timescale 1ns/10ps
`default_nettype none
`include "bbnio_params.svh"

module bbnio_regs (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Configuration access, byte offset with byte enables on a dword
    input  wire logic        i_cfg_wr,
    input  wire logic        i_cfg_rd,
    input  wire logic [7:0]  i_cfg_addr,
    input  wire logic [3:0]  i_cfg_be,
    input  wire logic [31:0] i_cfg_wdata,
    output logic      [31:0] o_cfg_rdata,
    output logic             o_cfg_rvalid,
    output logic             o_cfg_hit,
    // Type 1 configuration request steering
    input  wire logic        i_t1_valid,
    input  wire logic [7:0]  i_t1_bus,
    output logic             o_t1_to_type0,
    output logic             o_t1_pass_type1,
    output logic             o_t1_reject,
    // I/O request window check
    input  wire logic        i_io_valid,
    input  wire logic [31:0] i_io_addr,
    output logic             o_io_forward,
    // Register values for the downstream side
    output logic      [7:0]  o_upstream_bus_num,
    output logic      [7:0]  o_downstream_bus_num,
    output logic      [7:0]  o_highest_downstream_bus_num,
    output logic      [7:0]  o_downstream_latency_timer,
    output logic      [31:0] o_io_bottom,
    output logic      [31:0] o_io_top
);

    // Reset release
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Register state
    logic [7:0]  up_bus_q,  up_bus_d;
    logic [7:0]  dn_bus_q,  dn_bus_d;
    logic [7:0]  hi_bus_q,  hi_bus_d;
    logic [7:0]  lat_q,     lat_d;
    logic [3:0]  bot_nib_q, bot_nib_d;
    logic [3:0]  top_nib_q, top_nib_d;
    logic [15:0] bot_up_q,  bot_up_d;
    logic [15:0] top_up_q,  top_up_d;

    logic [7:0]  dword_addr;
    logic        sel_18;
    logic        sel_1c;
    logic        sel_30;

    always_comb begin
        dword_addr = {i_cfg_addr[7:2], 2'b00};
        sel_18     = (dword_addr == `BBNIO_OFF_UP_BUS);
        sel_1c     = (dword_addr == `BBNIO_OFF_IO_BOT);
        sel_30     = (dword_addr == `BBNIO_OFF_IO_BOT_UP);
        up_bus_d   = up_bus_q;
        dn_bus_d   = dn_bus_q;
        hi_bus_d   = hi_bus_q;
        lat_d      = lat_q;
        bot_nib_d  = bot_nib_q;
        top_nib_d  = top_nib_q;
        bot_up_d   = bot_up_q;
        top_up_d   = top_up_q;
        if (i_cfg_wr && sel_18) begin
            if (i_cfg_be[0]) up_bus_d = i_cfg_wdata[7:0];    // [RQ1]
            if (i_cfg_be[1]) dn_bus_d = i_cfg_wdata[15:8];   // [RQ2]
            if (i_cfg_be[2]) hi_bus_d = i_cfg_wdata[23:16];  // [RQ3]
            if (i_cfg_be[3]) lat_d    = i_cfg_wdata[31:24];  // [RQ5]
        end
        // Only the upper nibbles take writes; low nibbles are fixed
        if (i_cfg_wr && sel_1c) begin
            if (i_cfg_be[0]) bot_nib_d = i_cfg_wdata[7:4];   // [RQ8] [RQ10]
            if (i_cfg_be[1]) top_nib_d = i_cfg_wdata[15:12]; // [RQ9] [RQ10]
        end
        if (i_cfg_wr && sel_30) begin
            if (i_cfg_be[0]) bot_up_d[7:0]  = i_cfg_wdata[7:0];   // [RQ11]
            if (i_cfg_be[1]) bot_up_d[15:8] = i_cfg_wdata[15:8];  // [RQ11]
            if (i_cfg_be[2]) top_up_d[7:0]  = i_cfg_wdata[23:16]; // [RQ12]
            if (i_cfg_be[3]) top_up_d[15:8] = i_cfg_wdata[31:24]; // [RQ12]
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            up_bus_q  <= `BBNIO_RST_BYTE;   // [RQ1]
            dn_bus_q  <= `BBNIO_RST_BYTE;   // [RQ2]
            hi_bus_q  <= `BBNIO_RST_BYTE;   // [RQ3]
            lat_q     <= `BBNIO_RST_BYTE;   // [RQ5]
            bot_nib_q <= `BBNIO_RST_NIBBLE;
            top_nib_q <= `BBNIO_RST_NIBBLE;
            bot_up_q  <= `BBNIO_RST_UPPER;
            top_up_q  <= `BBNIO_RST_UPPER;
        end else begin
            up_bus_q  <= up_bus_d;
            dn_bus_q  <= dn_bus_d;
            hi_bus_q  <= hi_bus_d;
            lat_q     <= lat_d;
            bot_nib_q <= bot_nib_d;
            top_nib_q <= top_nib_d;
            bot_up_q  <= bot_up_d;
            top_up_q  <= top_up_d;
        end
    end

    // Window and steering
    logic [31:0]             win_bottom;
    logic [31:0]             win_top;
    logic                    win_hit;
    bbnio_pkg::bbnio_route_e route;

    bbnio_io_window u_io_window (
        .i_bot_nibble (bot_nib_q),
        .i_top_nibble (top_nib_q),
        .i_bot_upper  (bot_up_q),
        .i_top_upper  (top_up_q),
        .i_addr       (i_io_addr),
        .o_bottom     (win_bottom),
        .o_top        (win_top),
        .o_hit        (win_hit)
    );

    bbnio_cfg_route u_cfg_route (
        .i_dn_bus     (dn_bus_q),
        .i_hi_bus     (hi_bus_q),
        .i_target_bus (i_t1_bus),
        .o_route      (route)
    );

    // Registered outputs
    logic [31:0] rdata_q,  rdata_d;
    logic        rvalid_q, rvalid_d;
    logic        hit_q,    hit_d;
    logic        t0_q,     t0_d;
    logic        t1_q,     t1_d;
    logic        rej_q,    rej_d;
    logic        fwd_q,    fwd_d;

    always_comb begin
        rdata_d  = 32'h00000000;
        hit_d    = 1'b0;
        rvalid_d = i_cfg_rd;
        if (sel_18) begin
            hit_d   = i_cfg_wr | i_cfg_rd;
            rdata_d = {lat_q, hi_bus_q, dn_bus_q, up_bus_q};
        end else if (sel_1c) begin
            // Upper half holds secondary status, outside this bank
            hit_d   = i_cfg_wr | i_cfg_rd;
            rdata_d = {16'h0000, top_nib_q, `BBNIO_IO_WIDTH_CODE,
                       bot_nib_q, `BBNIO_IO_WIDTH_CODE};  // [RQ10]
        end else if (sel_30) begin
            hit_d   = i_cfg_wr | i_cfg_rd;
            rdata_d = {top_up_q, bot_up_q};
        end
        if (!i_cfg_rd) begin
            rdata_d = 32'h00000000;
        end
        t0_d  = i_t1_valid && (route == bbnio_pkg::BBNIO_CFG_TO_TYPE0);   // [RQ14]
        t1_d  = i_t1_valid && (route == bbnio_pkg::BBNIO_CFG_PASS_TYPE1); // [RQ14]
        rej_d = i_t1_valid && (route == bbnio_pkg::BBNIO_CFG_NONE);       // [RQ4]
        fwd_d = i_io_valid && win_hit;                                    // [RQ13]
    end

    always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata_q  <= 32'h00000000;
            rvalid_q <= 1'b0;
            hit_q    <= 1'b0;
            t0_q     <= 1'b0;
            t1_q     <= 1'b0;
            rej_q    <= 1'b0;
            fwd_q    <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            hit_q    <= hit_d;
            t0_q     <= t0_d;
            t1_q     <= t1_d;
            rej_q    <= rej_d;
            fwd_q    <= fwd_d;
        end
    end

    // Window bounds registered for the downstream side
    logic [31:0] bot_out_q;
    logic [31:0] top_out_q;

    always_ff @(posedge i_ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            bot_out_q <= {`BBNIO_RST_UPPER, `BBNIO_RST_NIBBLE, `BBNIO_IO_BOT_LOW};
            top_out_q <= {`BBNIO_RST_UPPER, `BBNIO_RST_NIBBLE, `BBNIO_IO_TOP_LOW};
        end else begin
            bot_out_q <= win_bottom; // [RQ6]
            top_out_q <= win_top;    // [RQ7]
        end
    end

    assign o_cfg_rdata                  = rdata_q;
    assign o_cfg_rvalid                 = rvalid_q;
    assign o_cfg_hit                    = hit_q;
    assign o_t1_to_type0                = t0_q;
    assign o_t1_pass_type1              = t1_q;
    assign o_t1_reject                  = rej_q;
    assign o_io_forward                 = fwd_q;
    assign o_upstream_bus_num           = up_bus_q;
    assign o_downstream_bus_num         = dn_bus_q;
    assign o_highest_downstream_bus_num = hi_bus_q;
    assign o_downstream_latency_timer   = lat_q;
    assign o_io_bottom                  = bot_out_q;
    assign o_io_top                     = top_out_q;

endmodule // bbnio_regs
`default_nettype wire
